// [hw/amea_cfg.svh]
/*
  timing-free constants for the addressing-mode and effective-address unit:
  opcode field positions, instruction lengths, region limits and reset values.
  assumes it is included by bare name from the package and the design file.
*/
`ifndef AMEA_CFG_SVH
`define AMEA_CFG_SVH

// ==========================================================================
// instruction lengths in bytes
`define AMEA_LEN_ONE 2'h1
`define AMEA_LEN_TWO 2'h2
`define AMEA_LEN_THREE 2'h3

// ==========================================================================
// opcode fields
`define AMEA_BITNUM_LSB 1
`define AMEA_COND_BIT 0
`define AMEA_BITOP_HI 4'h0
`define AMEA_BSC_HI 4'h1
`define AMEA_REL_HI 4'h2
`define AMEA_IMM_HI 4'hA
`define AMEA_DIR_HI 4'hB
`define AMEA_EXT_HI 4'hC
`define AMEA_IX2_HI 4'hD
`define AMEA_IX1_HI 4'hE
`define AMEA_IX_HI 4'hF

// ==========================================================================
// reset values and region limits
`define AMEA_ADDR_RST 16'h0000
`define AMEA_DIRECT_TOP 16'h00FF
`define AMEA_EPROM_LOW_BYTES 16'h0080

`endif

// [hw/amea_pkg.sv]
/*
  types for the addressing-mode and effective-address unit.
  assumes nothing beyond the constants header.
*/
package amea_pkg;
  `include "amea_cfg.svh"

  // ==========================================================================
  // addressing modes
  typedef enum logic [3:0] {
    AMEA_INH = 4'h0,
    AMEA_IMM = 4'h1,
    AMEA_DIR = 4'h2,
    AMEA_EXT = 4'h3,
    AMEA_REL = 4'h4,
    AMEA_IX = 4'h5,
    AMEA_IX1 = 4'h6,
    AMEA_IX2 = 4'h7,
    AMEA_BSC = 4'h8,
    AMEA_BTB = 4'h9
  } amea_mode_t;

  // ==========================================================================
  // decoder states, gray along fetch path
  typedef enum logic [1:0] {
    AMEA_IDLE = 2'b00,
    AMEA_BYTE1 = 2'b01,
    AMEA_BYTE2 = 2'b11,
    AMEA_DONE = 2'b10
  } amea_state_t;
endpackage

// [hw/amea_unit.sv]
/*
  addressing-mode decoder and effective-address generator of an 8-bit core.
  assumes the fetch path presents the opcode, then each following byte, with
  a one-cycle valid strobe each, and supplies the index register and the
  byte read from the direct address for bit tests.
*/
// What this block does
// - bit set/clear: bit number from opcode, address from next byte, 2 bytes.
// - after bit test-and-branch, carry takes the tested bit value.
// - bit test-and-branch is 3 bytes; offset added only when true.
// - immediate mode: byte after opcode is the operand value.
// - direct mode: one byte after opcode is address, 2 bytes long.
// - the direct region spans RAM, I/O and 128 EPROM bytes.
// - extended mode: two bytes after opcode form address, 3 bytes.
// - relative branch adds signed offset only when condition holds.
// - indexed no offset: index register is the address, one byte.
// - indexed 8-bit offset: unsigned index plus unsigned byte, 2 bytes.
// - indexed 16-bit offset: index plus two-byte value, 3 bytes.
// - inherent instructions are one byte, all in the opcode.
`timescale 1ns/1ps
`include "amea_cfg.svh"
module amea_unit
  import amea_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic OP_VALID,
  input wire logic [7:0] OP_BYTE,
  input wire logic ARG_VALID,
  input wire logic [7:0] ARG_BYTE,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0] INDEX_REG,
  input wire logic BRANCH_COND,
  input wire logic TEST_VALID,
  input wire logic [7:0] TEST_BYTE,
  output logic [3:0] MODE,
  output logic [1:0] INSTR_LEN,
  output logic [15:0] EFFECTIVE_ADDRESS,
  output logic [7:0] OPERAND,
  output logic ADDR_VALID,
  output logic [2:0] BIT_NUM,
  output logic BIT_SET_OP,
  output logic BIT_CLEAR_OP,
  output logic CARRY_LOAD,
  output logic CARRY_VALUE,
  output logic [15:0] NEXT_PC,
  output logic PC_VALID
);

  // ==========================================================================
  // helpers
  // mode from opcode high nibble alone, low bits ignored
  function automatic amea_mode_t decode_mode(input logic [7:0] op);
    logic [3:0] hi;
    hi = op[7:4];
    case (hi)
      `AMEA_BITOP_HI: decode_mode = AMEA_BTB;
      `AMEA_BSC_HI: decode_mode = AMEA_BSC;
      `AMEA_REL_HI: decode_mode = AMEA_REL;
      `AMEA_IMM_HI: decode_mode = AMEA_IMM;
      `AMEA_DIR_HI: decode_mode = AMEA_DIR;
      `AMEA_EXT_HI: decode_mode = AMEA_EXT;
      `AMEA_IX2_HI: decode_mode = AMEA_IX2;
      `AMEA_IX1_HI: decode_mode = AMEA_IX1;
      `AMEA_IX_HI: decode_mode = AMEA_IX;
      default: decode_mode = AMEA_INH;
    endcase
  endfunction

  // length per mode
  function automatic logic [1:0] mode_len(input amea_mode_t m);
    case (m)
      AMEA_EXT, AMEA_IX2, AMEA_BTB: mode_len = `AMEA_LEN_THREE;
      AMEA_IMM, AMEA_DIR, AMEA_REL, AMEA_IX1, AMEA_BSC: mode_len = `AMEA_LEN_TWO;
      default: mode_len = `AMEA_LEN_ONE;
    endcase
  endfunction

  // pc plus instruction length plus sign-extended offset when taken
  function automatic logic [15:0] branch_target(input logic [15:0] pc, input logic [1:0] len,
                                                input logic [7:0] off, input logic take);
    logic [15:0] base;
    base = pc + {14'h0, len};
    branch_target = take ? base + {{8{off[7]}}, off} : base;
  endfunction

  // unsigned index register plus unsigned base, wrapping at 16 bits
  function automatic logic [15:0] index_add(input logic [15:0] base, input logic [7:0] ix);
    index_add = base + {8'h00, ix};
  endfunction

  // ==========================================================================
  // state
  amea_state_t state, next_state;
  amea_mode_t mode_q, next_mode_q;
  logic [7:0] opcode, next_opcode;
  logic [7:0] byte1, next_byte1;
  logic [15:0] pc_q, next_pc_q;
  logic [3:0] next_mode_out;
  logic [1:0] next_len;
  logic [15:0] next_addr;
  logic [7:0] next_operand;
  logic next_addr_valid, next_bit_set, next_bit_clear, next_carry_load, next_carry_value;
  logic [2:0] next_bit_num;
  logic [15:0] next_npc;
  logic next_pc_valid;
  logic tested;

  // next-state and output computation
  always_comb begin
    next_state = state;
    next_mode_q = mode_q;
    next_opcode = opcode;
    next_byte1 = byte1;
    next_pc_q = pc_q;
    next_mode_out = MODE;
    next_len = INSTR_LEN;
    next_addr = EFFECTIVE_ADDRESS;
    next_operand = OPERAND;
    next_addr_valid = 1'b0;
    next_bit_num = BIT_NUM;
    next_bit_set = 1'b0;
    next_bit_clear = 1'b0;
    next_carry_load = 1'b0;
    next_carry_value = CARRY_VALUE;
    next_npc = NEXT_PC;
    next_pc_valid = 1'b0;
    tested = TEST_BYTE[BIT_NUM];
    case (state)
      AMEA_IDLE: begin
        if (OP_VALID) begin
          next_opcode = OP_BYTE;
          next_mode_q = decode_mode(OP_BYTE);
          next_pc_q = PC_IN;
          next_mode_out = decode_mode(OP_BYTE);
          next_len = mode_len(decode_mode(OP_BYTE));
          next_bit_num = OP_BYTE[3:1];
          if (decode_mode(OP_BYTE) == AMEA_IX) begin
            next_addr = {8'h00, INDEX_REG};
            next_addr_valid = 1'b1;
            next_npc = PC_IN + 16'h0001;
            next_pc_valid = 1'b1;
          end else if (decode_mode(OP_BYTE) == AMEA_INH) begin
            next_npc = PC_IN + 16'h0001;
            next_pc_valid = 1'b1;
          end else begin
            next_state = AMEA_BYTE1;
          end
        end
      end
      AMEA_BYTE1: begin
        if (ARG_VALID) begin
          next_byte1 = ARG_BYTE;
          next_state = AMEA_IDLE;
          next_npc = pc_q + {14'h0, `AMEA_LEN_TWO};
          next_pc_valid = 1'b1;
          case (mode_q)
            AMEA_IMM: next_operand = ARG_BYTE;
            AMEA_DIR: begin
              next_addr = {8'h00, ARG_BYTE};
              next_addr_valid = 1'b1;
            end
            AMEA_IX1: begin
              next_addr = index_add({8'h00, ARG_BYTE}, INDEX_REG);
              next_addr_valid = 1'b1;
            end
            AMEA_BSC: begin
              next_addr = {8'h00, ARG_BYTE};
              next_addr_valid = 1'b1;
              next_bit_set = ~opcode[`AMEA_COND_BIT];
              next_bit_clear = opcode[`AMEA_COND_BIT];
            end
            AMEA_REL: begin
              next_npc = branch_target(pc_q, `AMEA_LEN_TWO, ARG_BYTE, BRANCH_COND);
            end
            AMEA_BTB: begin
              next_addr = {8'h00, ARG_BYTE};
              next_addr_valid = 1'b1;
              next_pc_valid = 1'b0;
              next_state = AMEA_BYTE2;
            end
            default: begin
              next_pc_valid = 1'b0;
              next_state = AMEA_BYTE2;
            end
          endcase
        end
      end
      AMEA_BYTE2: begin
        if (ARG_VALID && (mode_q != AMEA_BTB || TEST_VALID)) begin
          next_state = AMEA_IDLE;
          next_npc = pc_q + {14'h0, `AMEA_LEN_THREE};
          next_pc_valid = 1'b1;
          case (mode_q)
            AMEA_EXT: begin
              next_addr = {byte1, ARG_BYTE};
              next_addr_valid = 1'b1;
            end
            AMEA_IX2: begin
              next_addr = index_add({byte1, ARG_BYTE}, INDEX_REG);
              next_addr_valid = 1'b1;
            end
            AMEA_BTB: begin
              // branch on set when cond bit low, on clear when high
              next_npc = branch_target(pc_q, `AMEA_LEN_THREE, ARG_BYTE,
                                       tested ^ opcode[`AMEA_COND_BIT]);
              next_carry_load = 1'b1;
              next_carry_value = tested;
            end
            default: next_pc_valid = 1'b1;
          endcase
        end
      end
      default: next_state = AMEA_IDLE;
    endcase
  end

  // registers
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state <= AMEA_IDLE;
      mode_q <= AMEA_INH;
      opcode <= 8'h00;
      byte1 <= 8'h00;
      pc_q <= `AMEA_ADDR_RST;
      MODE <= 4'h0;
      INSTR_LEN <= 2'h0;
      EFFECTIVE_ADDRESS <= `AMEA_ADDR_RST;
      OPERAND <= 8'h00;
      ADDR_VALID <= 1'b0;
      BIT_NUM <= 3'h0;
      BIT_SET_OP <= 1'b0;
      BIT_CLEAR_OP <= 1'b0;
      CARRY_LOAD <= 1'b0;
      CARRY_VALUE <= 1'b0;
      NEXT_PC <= `AMEA_ADDR_RST;
      PC_VALID <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= next_mode_q;
      opcode <= next_opcode;
      byte1 <= next_byte1;
      pc_q <= next_pc_q;
      MODE <= next_mode_out;
      INSTR_LEN <= next_len;
      EFFECTIVE_ADDRESS <= next_addr;
      OPERAND <= next_operand;
      ADDR_VALID <= next_addr_valid;
      BIT_NUM <= next_bit_num;
      BIT_SET_OP <= next_bit_set;
      BIT_CLEAR_OP <= next_bit_clear;
      CARRY_LOAD <= next_carry_load;
      CARRY_VALUE <= next_carry_value;
      NEXT_PC <= next_npc;
      PC_VALID <= next_pc_valid;
    end
  end

  // ==========================================================================
  // assertions
  property p_len_matches_mode;
    @(posedge CLK) disable iff (!RESET_N)
    PC_VALID && (MODE == AMEA_EXT || MODE == AMEA_IX2 || MODE == AMEA_BTB)
      |-> INSTR_LEN == `AMEA_LEN_THREE;
  endproperty
  a_len_matches_mode: assert property (p_len_matches_mode) else $error("length not 3");

  property p_inherent_one;
    @(posedge CLK) disable iff (!RESET_N)
    PC_VALID && (MODE == AMEA_INH || MODE == AMEA_IX) |-> INSTR_LEN == `AMEA_LEN_ONE;
  endproperty
  a_inherent_one: assert property (p_inherent_one) else $error("one-byte length wrong");

  property p_carry_btb;
    @(posedge CLK) disable iff (!RESET_N)
    state == AMEA_BYTE2 && mode_q == AMEA_BTB && ARG_VALID && TEST_VALID
      |=> CARRY_LOAD && CARRY_VALUE == $past(tested);
  endproperty
  a_carry_btb: assert property (p_carry_btb) else $error("carry not tested bit");

  property p_direct_page;
    @(posedge CLK) disable iff (!RESET_N)
    ADDR_VALID && (MODE == AMEA_DIR || MODE == AMEA_BSC || MODE == AMEA_IX)
      |-> EFFECTIVE_ADDRESS <= `AMEA_DIRECT_TOP;
  endproperty
  a_direct_page: assert property (p_direct_page) else $error("direct address off page");

  property p_ix1_sum;
    @(posedge CLK) disable iff (!RESET_N)
    state == AMEA_BYTE1 && mode_q == AMEA_IX1 && ARG_VALID
      |=> ADDR_VALID
        && EFFECTIVE_ADDRESS == {8'h00, $past(ARG_BYTE)} + {8'h00, $past(INDEX_REG)};
  endproperty
  a_ix1_sum: assert property (p_ix1_sum) else $error("indexed 8-bit address wrong");

  property p_rel_not_taken;
    @(posedge CLK) disable iff (!RESET_N)
    state == AMEA_BYTE1 && mode_q == AMEA_REL && ARG_VALID && !BRANCH_COND
      |=> PC_VALID && NEXT_PC == $past(pc_q) + 16'h0002;
  endproperty
  a_rel_not_taken: assert property (p_rel_not_taken) else $error("untaken branch");

  property p_bsc_one_op;
    @(posedge CLK) disable iff (!RESET_N)
    !(BIT_SET_OP && BIT_CLEAR_OP);
  endproperty
  a_bsc_one_op: assert property (p_bsc_one_op) else $error("set and clear together");

  property p_ext_done;
    @(posedge CLK) disable iff (!RESET_N)
    OP_VALID && state == AMEA_IDLE && OP_BYTE[7:4] == `AMEA_EXT_HI
      |=> ##[1:300] ADDR_VALID;
  endproperty
  a_ext_done: assert property (p_ext_done) else $error("extended address missing");

  c_btb: cover property (@(posedge CLK) disable iff (!RESET_N) CARRY_LOAD);
  c_bit_set: cover property (@(posedge CLK) disable iff (!RESET_N) BIT_SET_OP);
  c_rel_taken: cover property (@(posedge CLK) disable iff (!RESET_N)
    state == AMEA_BYTE1 && mode_q == AMEA_REL && ARG_VALID && BRANCH_COND);
endmodule

// [verification/amea_mem.sv]
/*
  program and data memory model that feeds instruction bytes to the unit.
  assumes the bench fills prog and data and calls issue at a falling edge.
*/
`timescale 1ns/1ps
module amea_mem (
  input wire logic clk,
  output logic op_valid,
  output logic [7:0] op_byte,
  output logic arg_valid,
  output logic [7:0] arg_byte,
  output logic [15:0] pc_in,
  output logic test_valid,
  output logic [7:0] test_byte
);
  // ==========================================================================
  // storage, program image never bit-modifies direction registers
  logic [7:0] prog [0:255];
  logic [7:0] data [0:255];

  // idle lines start low
  initial begin
    op_valid = 1'b0;
    op_byte = 8'h00;
    arg_valid = 1'b0;
    arg_byte = 8'h00;
    pc_in = 16'h0000;
    test_valid = 1'b0;
    test_byte = 8'h00;
  end

  // ==========================================================================
  // one byte per cycle; the tested byte comes with the third byte of a bit test
  task automatic issue(input logic [15:0] pc, input logic [1:0] len, input logic bit_test);
    int i;
    op_valid = 1'b1;
    op_byte = prog[pc[7:0]];
    pc_in = pc;
    for (i = 1; i < len; i++) begin
      @(negedge clk);
      op_valid = 1'b0;
      op_byte = ~op_byte;
      arg_valid = 1'b1;
      arg_byte = prog[pc[7:0] + i[7:0]];
      if (bit_test && i == 2) begin
        test_valid = 1'b1;
        test_byte = data[prog[pc[7:0] + 8'h01]];
      end
    end
    @(negedge clk);
    // released lines show the inverse so stale values never look valid
    op_valid = 1'b0;
    arg_valid = 1'b0;
    test_valid = 1'b0;
    op_byte = ~op_byte;
    arg_byte = ~arg_byte;
    test_byte = ~test_byte;
  endtask
endmodule

// [verification/testbench.sv]
/*
  self-checking bench for the addressing-mode unit, one task per scenario.
  assumes the memory model drives the fetch side and the bench the rest.
*/
`timescale 1ns/1ps
module testbench;
  import amea_pkg::*;
  logic clk, reset_n, op_valid, arg_valid, branch_cond, test_valid, addr_valid;
  logic bit_set_op, bit_clear_op, carry_load, carry_value, pc_valid;
  logic [7:0] op_byte, arg_byte, index_reg, test_byte, operand;
  logic [15:0] pc_in, effective_address, next_pc, pc_now;
  logic [3:0] mode;
  logic [1:0] instr_len;
  logic [2:0] bit_num;
  int miscompares, checks_done;

  amea_unit amea_unit_i (.CLK(clk), .RESET_N(reset_n), .OP_VALID(op_valid),
    .OP_BYTE(op_byte), .ARG_VALID(arg_valid), .ARG_BYTE(arg_byte), .PC_IN(pc_in),
    .INDEX_REG(index_reg), .BRANCH_COND(branch_cond), .TEST_VALID(test_valid),
    .TEST_BYTE(test_byte), .MODE(mode), .INSTR_LEN(instr_len),
    .EFFECTIVE_ADDRESS(effective_address), .OPERAND(operand), .ADDR_VALID(addr_valid),
    .BIT_NUM(bit_num), .BIT_SET_OP(bit_set_op), .BIT_CLEAR_OP(bit_clear_op),
    .CARRY_LOAD(carry_load), .CARRY_VALUE(carry_value), .NEXT_PC(next_pc),
    .PC_VALID(pc_valid));
  amea_mem amea_mem_i (.clk(clk), .op_valid(op_valid), .op_byte(op_byte),
    .arg_valid(arg_valid), .arg_byte(arg_byte), .pc_in(pc_in),
    .test_valid(test_valid), .test_byte(test_byte));

  // ==========================================================================
  // clock and shared tasks
  always #4 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // load one instruction, run it and judge the result cycle and the cycle after
  task automatic instr(input logic [7:0] op, b1, b2, input logic [1:0] len,
    input logic [3:0] e_mode, input logic [15:0] e_addr, input logic eav, e_npc_dummy,
    input logic [15:0] e_npc);
    amea_mem_i.prog[pc_now[7:0]] = op;
    amea_mem_i.prog[pc_now[7:0] + 8'h01] = b1;
    amea_mem_i.prog[pc_now[7:0] + 8'h02] = b2;
    amea_mem_i.issue(pc_now, len, e_mode == 4'h9);
    check(16'(mode), 16'(e_mode));
    check(16'(instr_len), 16'(len));
    check(16'(pc_valid), 16'h0001);
    check(next_pc, e_npc);
    check(16'(addr_valid), 16'(eav));
    if (e_mode != 4'h0 && e_mode != 4'h1 && e_mode != 4'h4)
      check(effective_address, e_addr);
    if (e_mode == 4'h1) check(16'(operand), 16'(b1));
    if (e_mode >= 4'h8) check(16'(bit_num), 16'(op[3:1]));
    if (e_mode == 4'h8) check(16'({bit_set_op, bit_clear_op}), 16'({~op[0], op[0]}));
    if (e_mode == 4'h9)
      check(16'({carry_load, carry_value}), 16'({1'b1, amea_mem_i.data[b1][op[3:1]]}));
    @(negedge clk);
    check(16'({pc_valid, addr_valid}), 16'h0000);
    pc_now = pc_now + 16'h0010;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    check(16'({mode, pc_valid, addr_valid}), 16'h0000);
    check(next_pc, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_modes();
    instr(8'h4C, 8'h00, 8'h00, 2'h1, 4'h0, 16'h0000, 1'b0, 1'b0, pc_now + 16'h0001);
    instr(8'hA6, 8'h5A, 8'h00, 2'h2, 4'h1, 16'h0000, 1'b0, 1'b0, pc_now + 16'h0002);
    instr(8'hB6, 8'hFF, 8'h00, 2'h2, 4'h2, 16'h00FF, 1'b1, 1'b0, pc_now + 16'h0002);
    instr(8'hB6, 8'h80, 8'h00, 2'h2, 4'h2, 16'h0080, 1'b1, 1'b0, pc_now + 16'h0002);
    instr(8'hC6, 8'h12, 8'h34, 2'h3, 4'h3, 16'h1234, 1'b1, 1'b0, pc_now + 16'h0003);
    index_reg = 8'h9C;
    instr(8'hF6, 8'h00, 8'h00, 2'h1, 4'h5, 16'h009C, 1'b1, 1'b0, pc_now + 16'h0001);
    index_reg = 8'hFF;
    instr(8'hE6, 8'hFF, 8'h00, 2'h2, 4'h6, 16'h01FE, 1'b1, 1'b0, pc_now + 16'h0002);
    index_reg = 8'h80;
    instr(8'hD6, 8'hF0, 8'h10, 2'h3, 4'h7, 16'hF090, 1'b1, 1'b0, pc_now + 16'h0003);
    $display("test modes done");
  endtask

  task automatic t_rel();
    branch_cond = 1'b1;
    instr(8'h26, 8'h7F, 8'h00, 2'h2, 4'h4, 16'h0000, 1'b0, 1'b0, pc_now + 16'h0081);
    instr(8'h26, 8'h80, 8'h00, 2'h2, 4'h4, 16'h0000, 1'b0, 1'b0, pc_now - 16'h007E);
    branch_cond = 1'b0;
    instr(8'h26, 8'h7F, 8'h00, 2'h2, 4'h4, 16'h0000, 1'b0, 1'b0, pc_now + 16'h0002);
    $display("test relative done");
  endtask

  task automatic t_bits();
    int i;
    logic take;
    for (i = 0; i < 16; i++) begin
      instr(8'h10 + i[7:0], 8'h40 + i[7:0], 8'h00, 2'h2, 4'h8, 16'h0040 + i[15:0], 1'b1,
        1'b0, pc_now + 16'h0002);
      amea_mem_i.data[8'h20 + i[7:0]] = 8'hA5 ^ {8{i[3]}};
      take = amea_mem_i.data[8'h20 + i[7:0]][i[3:1]] ^ i[0];
      instr(i[7:0], 8'h20 + i[7:0], 8'h7F, 2'h3, 4'h9, 16'h0020 + i[15:0], 1'b0, 1'b0,
        pc_now + (take ? 16'h0082 : 16'h0003));
    end
    $display("test bit operations done");
  endtask

  // ==========================================================================
  // verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(8 * 4000);
    miscompares++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    index_reg = 8'h00;
    branch_cond = 1'b0;
    miscompares = 0;
    checks_done = 0;
    pc_now = 16'h1230;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_modes();
    t_rel();
    t_bits();
    conclude();
  end
endmodule
